// *** common/sfe_pkg.sv ***
// shared constants of the serial flash instruction front end
package sfe_pkg;
    // opcodes
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_VSR_WREN = 8'h50;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_SUSPEND = 8'h75;
    localparam logic [7:0] OP_RESUME = 8'h7a;
    localparam logic [7:0] OP_RELEASE_ID = 8'hab;
    localparam logic [7:0] OP_POWER_DOWN = 8'hb9;
    localparam logic [7:0] OP_ID_SINGLE = 8'h90;
    localparam logic [7:0] OP_ID_DUAL = 8'h92;
    localparam logic [7:0] OP_ID_QUAD = 8'h94;
    localparam logic [7:0] OP_ID_LONG = 8'h9f;
    localparam logic [7:0] OP_READ_DUAL = 8'h3b;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_READ_FAST = 8'h0b;
    localparam logic [7:0] OP_STAT_LO = 8'h05;
    localparam logic [7:0] OP_STAT_HI = 8'h35;
    localparam logic [7:0] OP_STAT_WRITE = 8'h01;
    localparam logic [7:0] OP_PAGE_PROG = 8'h02;
    localparam logic [7:0] OP_ERASE_4K = 8'h20;
    localparam logic [7:0] OP_ERASE_32K = 8'h52;
    localparam logic [7:0] OP_ERASE_64K = 8'hd8;
    localparam logic [7:0] OP_CHIP_ERASE_A = 8'hc7;
    localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
    localparam logic [7:0] OP_ENTER_QUAD = 8'h38;

    // byte index at which output data starts, zero when none
    localparam logic [3:0] OUT_AT_NONE = 4'h0;
    localparam logic [3:0] OUT_AT_1 = 4'h1;
    localparam logic [3:0] OUT_AT_4 = 4'h4;
    localparam logic [3:0] OUT_AT_5 = 4'h5;
    localparam logic [3:0] IDX_ADDR_DONE = 4'h4;
    localparam logic [3:0] IDX_MAX = 4'hf;
    localparam logic [3:0] IDX_ONE = 4'h1;
    localparam logic [3:0] IDX_TWO = 4'h2;
    localparam logic [3:0] IDX_THREE = 4'h3;
    localparam logic [3:0] IDX_PROG_MIN = 4'h5;

    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] STEP_1 = 4'h1;
    localparam logic [3:0] STEP_2 = 4'h2;
    localparam logic [3:0] STEP_4 = 4'h4;

    // region masks for the protection overlap check
    localparam logic [23:0] MASK_PAGE = 24'h0000ff;
    localparam logic [23:0] MASK_4K = 24'h000fff;
    localparam logic [23:0] MASK_32K = 24'h007fff;
    localparam logic [23:0] MASK_64K = 24'h00ffff;
    localparam logic [23:0] MASK_ALL = 24'hffffff;
    localparam logic [23:0] ADDR_ONE = 24'h000001;

    // command stream toward the array back end
    localparam int CMD_W = 10;
    localparam int CMD_DEPTH = 8;
    localparam logic [1:0] KIND_OPCODE = 2'h0;
    localparam logic [1:0] KIND_BYTE = 2'h1;
    localparam logic [1:0] KIND_COMMIT = 2'h2;
    localparam logic [1:0] KIND_ABORT = 2'h3;

    typedef enum logic [1:0] {
        SFE_IDLE,
        SFE_BODY,
        SFE_SKIP,
        SFE_FINISH
    } sfe_state_e;
endpackage

// *** rtl/sfe_front_end.sv ***
// serial flash instruction front end with its command fifo
`timescale 1ns/1ps
`default_nettype none

module sfe_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input wire logic clk, // core clock
    input wire logic rst_n, // synchronous reset, low
    input wire logic in_valid, // word offered
    output logic in_ready, // room for a word
    input wire logic [W-1:0] in_data, // word in
    output logic out_valid, // word available
    input wire logic out_ready, // word taken
    output logic [W-1:0] out_data // oldest word
);
    localparam int AW = $clog2(D);
    localparam logic [AW:0] FULL = (AW+1)'(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = (count != FULL);
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= push ? AW'(wr_ptr + 1'b1) : wr_ptr;
            rd_ptr <= pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
            count <= (AW+1)'(count + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0));
        end
    end
endmodule

module sfe_front_end import sfe_pkg::*; #(
    parameter logic [7:0] MAKER_CODE = 8'h5a, // arbitrary value
    parameter logic [7:0] PART_CODE = 8'h3c, // arbitrary value
    parameter logic [7:0] TYPE_CODE = 8'h71, // arbitrary value
    parameter logic [7:0] SIZE_CODE = 8'h2e // arbitrary value
) (
    input wire logic clk, // core clock
    input wire logic rst_n, // reset, low; synchronous on the core side, asynchronous for the link-side toggles and tx_ack
    input wire logic sclk, // link clock from host
    input wire logic cs_n, // select, low during an instruction
    input wire logic [3:0] io_in, // data lines in; bit 0 is serial_in_line
    output logic [3:0] io_out, // data lines out
    output logic [3:0] io_oe, // data line drive enables
    input wire logic [15:0] status_in, // status_high_bits and status_low_bits
    input wire logic busy_in, // program, erase or status write running
    input wire logic prot_en, // protected range valid
    input wire logic [23:0] prot_base, // first protected address
    input wire logic [23:0] prot_limit, // last protected address
    output logic rd_strobe, // array read request pulse
    output logic [23:0] rd_addr, // array read address
    input wire logic rd_valid, // array read data valid
    input wire logic [7:0] rd_data, // array read data
    output logic cmd_valid, // command word available
    input wire logic cmd_ready, // command word taken
    output logic [1:0] cmd_kind, // opcode, byte, commit or abort
    output logic [7:0] cmd_data, // command byte
    output logic write_enable, // write enable latch
    output logic volatile_sr_enable, // volatile status write enable
    output logic power_down, // deep power-down state
    output logic four_line_command_mode, // four-line command mode
    output logic suspend_req, // suspend pulse
    output logic resume_req // resume pulse
);
    // snapshots taken between frames, read quasi-static by the link side
    logic [15:0] snap_stat;
    logic snap_allow;
    logic snap_pd;

    // link side
    logic [7:0] sh;
    logic [7:0] opc;
    logic [3:0] idx;
    logic [3:0] pos;
    logic [7:0] rx_byte;
    logic rx_tgl;
    logic edge_tgl;
    logic [7:0] out_sh;
    logic out_on;
    logic tx_ack;
    logic [7:0] tx_hold;

    wire quad = four_line_command_mode;
    wire dual_in = (opc == OP_ID_DUAL) && (idx != '0) && (idx < OUT_AT_5);
    wire dual_out = (opc == OP_ID_DUAL) || (opc == OP_READ_DUAL);
    wire two_step = dual_in || (dual_out && (idx >= OUT_AT_5));
    wire [3:0] step = quad ? STEP_4 : (two_step ? STEP_2 : STEP_1);
    wire [3:0] pos_next = pos + step;
    wire byte_done = (pos_next == BITS_PER_BYTE);
    wire [7:0] sh_next = quad ? {sh[3:0], io_in} :
                         dual_in ? {sh[5:0], io_in[1:0]} : {sh[6:0], io_in[0]};

    // frame state: select high clears it, so a stopped clock needs no edge
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            sh <= '0;
            opc <= '0;
            idx <= '0;
            pos <= '0;
        end else begin
            sh <= sh_next;
            pos <= byte_done ? '0 : pos_next;
            if (byte_done && idx != IDX_MAX) begin
                idx <= idx + IDX_ONE;
            end
            if (byte_done && idx == '0) begin
                opc <= sh_next;
            end
        end
    end

    // event toggles persist across frames
    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            rx_byte <= '0;
            rx_tgl <= 1'b0;
            edge_tgl <= 1'b0;
        end else begin
            edge_tgl <= ~edge_tgl;
            if (byte_done) begin
                rx_byte <= sh_next;
                rx_tgl <= ~rx_tgl;
            end
        end
    end

    logic [3:0] out_at;
    always_comb begin
        unique case (opc)
            OP_STAT_LO, OP_STAT_HI, OP_ID_LONG: out_at = OUT_AT_1;
            OP_READ, OP_RELEASE_ID, OP_ID_SINGLE: out_at = OUT_AT_4;
            OP_READ_FAST, OP_READ_DUAL, OP_ID_DUAL: out_at = OUT_AT_5;
            default: out_at = OUT_AT_NONE;
        endcase
    end

    // low status reads (05h) run while busy; ABh runs in power-down
    wire out_ok = snap_allow || (opc == OP_STAT_LO) || (opc == OP_RELEASE_ID && snap_pd);
    wire from_array = (opc == OP_READ) || (opc == OP_READ_FAST) || (opc == OP_READ_DUAL);
    wire load_now = (pos == '0) && (out_at != OUT_AT_NONE) && (idx >= out_at) && out_ok;

    logic [7:0] out_byte;
    always_comb begin
        unique case (opc)
            OP_STAT_LO: out_byte = snap_stat[7:0];
            OP_STAT_HI: out_byte = snap_stat[15:8];
            OP_ID_LONG: out_byte = (idx == IDX_ONE) ? MAKER_CODE :
                                   (idx == IDX_TWO) ? TYPE_CODE : SIZE_CODE;
            OP_RELEASE_ID: out_byte = PART_CODE;
            OP_ID_SINGLE: out_byte = idx[0] ? PART_CODE : MAKER_CODE;
            OP_ID_DUAL: out_byte = idx[0] ? MAKER_CODE : PART_CODE;
            default: out_byte = tx_hold;
        endcase
    end

    wire [7:0] out_shifted = quad ? {out_sh[3:0], 4'h0} :
                             dual_out ? {out_sh[5:0], 2'h0} : {out_sh[6:0], 1'b0};

    // data changes on the falling edge so the host samples it on the rising one
    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            out_sh <= '0;
            out_on <= 1'b0;
        end else begin
            out_sh <= load_now ? out_byte : out_shifted;
            out_on <= out_on || load_now;
        end
    end

    always_ff @(negedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            tx_ack <= 1'b0;
        end else if (load_now && from_array) begin
            tx_ack <= ~tx_ack;
        end
    end

    assign io_out = quad ? out_sh[7:4] :
                    dual_out ? {2'h0, out_sh[7:6]} : {2'h0, out_sh[7], 1'b0};
    assign io_oe = !out_on ? 4'h0 : quad ? 4'hf : dual_out ? 4'h3 : 4'h2;

    // core side
    logic cs_q1, cs_q2, cs_q3, cs_q4;
    logic rx_q1, rx_q2, rx_q3;
    logic ed_q1, ed_q2, ed_q3;
    logic ak_q1, ak_q2, ak_q3;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            {cs_q1, cs_q2, cs_q3, cs_q4} <= 4'hf;
            {rx_q1, rx_q2, rx_q3} <= 3'h0;
            {ed_q1, ed_q2, ed_q3} <= 3'h0;
            {ak_q1, ak_q2, ak_q3} <= 3'h0;
        end else begin
            {cs_q1, cs_q2, cs_q3, cs_q4} <= {cs_n, cs_q1, cs_q2, cs_q3};
            {rx_q1, rx_q2, rx_q3} <= {rx_tgl, rx_q1, rx_q2};
            {ed_q1, ed_q2, ed_q3} <= {edge_tgl, ed_q1, ed_q2};
            {ak_q1, ak_q2, ak_q3} <= {tx_ack, ak_q1, ak_q2};
        end
    end
    wire rx_evt = rx_q2 ^ rx_q3;
    wire edge_evt = ed_q2 ^ ed_q3;
    wire ack_evt = ak_q2 ^ ak_q3;
    // one stage later than the byte events so the last byte lands first
    wire end_evt = cs_q3 && !cs_q4;

    sfe_state_e state;
    logic [7:0] op;
    logic [3:0] nbytes;
    logic [23:0] addr;
    logic pushing;
    logic ovf;
    logic dirty;
    logic fin_ok;
    wire is_write = (op == OP_PAGE_PROG) || (op == OP_ERASE_4K) || (op == OP_ERASE_32K) ||
                    (op == OP_ERASE_64K) || (op == OP_CHIP_ERASE_A) ||
                    (op == OP_CHIP_ERASE_B) || (op == OP_STAT_WRITE);
    wire new_write = (rx_byte == OP_PAGE_PROG) || (rx_byte == OP_ERASE_4K) ||
                     (rx_byte == OP_ERASE_32K) || (rx_byte == OP_ERASE_64K) ||
                     (rx_byte == OP_CHIP_ERASE_A) || (rx_byte == OP_CHIP_ERASE_B) ||
                     (rx_byte == OP_STAT_WRITE);
    wire new_ok = (write_enable || (rx_byte == OP_STAT_WRITE && volatile_sr_enable));
    wire locked_out = (busy_in && rx_byte != OP_STAT_LO) ||
                      (power_down && rx_byte != OP_RELEASE_ID);
    wire [23:0] addr_next = {addr[15:0], rx_byte};
    wire is_read = (op == OP_READ) || (op == OP_READ_FAST) || (op == OP_READ_DUAL);

    logic [23:0] mask;
    always_comb begin
        unique case (op)
            OP_ERASE_4K: mask = MASK_4K;
            OP_ERASE_32K: mask = MASK_32K;
            OP_ERASE_64K: mask = MASK_64K;
            OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: mask = MASK_ALL;
            default: mask = MASK_PAGE;
        endcase
    end
    wire prot_hit = prot_en && (op != OP_STAT_WRITE) &&
                    ((addr & ~mask) <= prot_limit) && ((addr | mask) >= prot_base);
    wire chip = (op == OP_CHIP_ERASE_A) || (op == OP_CHIP_ERASE_B);
    wire count_ok = chip ? (nbytes == IDX_ONE) :
                    (op == OP_STAT_WRITE) ? (nbytes == IDX_TWO || nbytes == IDX_THREE) :
                    (op == OP_PAGE_PROG) ? (nbytes >= IDX_PROG_MIN) :
                    (nbytes == IDX_ADDR_DONE);
    wire commit_now = !ovf && !dirty && count_ok && !prot_hit;
    wire single_ok = (nbytes == IDX_ONE) && !dirty;

    wire fifo_ready;
    wire in_frame_body = (state == SFE_BODY) && pushing;
    wire take_byte = rx_evt && in_frame_body;
    wire push_first = rx_evt && (state == SFE_IDLE) && !locked_out && new_write && new_ok;
    wire push_valid = push_first || take_byte || (state == SFE_FINISH);
    wire [1:0] push_kind = (state == SFE_FINISH) ? (fin_ok ? KIND_COMMIT : KIND_ABORT) :
                           push_first ? KIND_OPCODE : KIND_BYTE;
    wire [CMD_W-1:0] push_word = {push_kind, rx_byte};
    wire [CMD_W-1:0] pop_word;

    sfe_fifo #(.W(CMD_W), .D(CMD_DEPTH)) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(push_valid),
        .in_ready(fifo_ready),
        .in_data(push_word),
        .out_valid(cmd_valid),
        .out_ready(cmd_ready),
        .out_data(pop_word)
    );
    assign cmd_kind = pop_word[CMD_W-1:CMD_W-2];
    assign cmd_data = pop_word[7:0];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= SFE_IDLE;
            op <= '0;
            nbytes <= '0;
            addr <= '0;
            pushing <= 1'b0;
            ovf <= 1'b0;
            fin_ok <= 1'b0;
        end else begin
            unique case (state)
                SFE_IDLE: if (rx_evt) begin
                    op <= rx_byte;
                    nbytes <= IDX_ONE;
                    ovf <= 1'b0;
                    pushing <= new_write && new_ok;
                    state <= locked_out ? SFE_SKIP : SFE_BODY;
                end
                SFE_BODY: if (end_evt) begin
                    fin_ok <= commit_now;
                    state <= (is_write && pushing) ? SFE_FINISH : SFE_IDLE;
                end else if (rx_evt) begin
                    nbytes <= (nbytes == IDX_MAX) ? nbytes : nbytes + IDX_ONE;
                    addr <= (nbytes < IDX_ADDR_DONE) ? addr_next : addr;
                    ovf <= ovf || (pushing && !fifo_ready);
                end
                SFE_SKIP: if (end_evt) begin
                    state <= SFE_IDLE;
                end
                SFE_FINISH: if (fifo_ready) begin
                    state <= SFE_IDLE;
                end
            endcase
        end
    end

    // a byte arriving with a stray edge leaves the frame on a boundary
    always_ff @(posedge clk) begin
        if (!rst_n || end_evt) begin
            dirty <= 1'b0;
        end else if (rx_evt) begin
            dirty <= 1'b0;
        end else if (edge_evt) begin
            dirty <= 1'b1;
        end
    end

    wire body_end = (state == SFE_BODY) && end_evt;
    wire commit_end = body_end && is_write && pushing && commit_now;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            write_enable <= 1'b0;
            volatile_sr_enable <= 1'b0;
            power_down <= 1'b0;
            four_line_command_mode <= 1'b0;
            suspend_req <= 1'b0;
            resume_req <= 1'b0;
        end else begin
            suspend_req <= body_end && single_ok && op == OP_SUSPEND;
            resume_req <= body_end && single_ok && op == OP_RESUME;
            if (commit_end || (body_end && single_ok && op == OP_WRDI)) begin
                write_enable <= 1'b0;
            end else if (body_end && single_ok && op == OP_WREN) begin
                write_enable <= 1'b1;
            end
            if (commit_end) begin
                volatile_sr_enable <= 1'b0;
            end else if (body_end && single_ok && op == OP_VSR_WREN) begin
                volatile_sr_enable <= 1'b1;
            end
            if (body_end && op == OP_RELEASE_ID) begin
                power_down <= 1'b0;
            end else if (body_end && single_ok && op == OP_POWER_DOWN) begin
                power_down <= 1'b1;
            end
            if (body_end && single_ok && op == OP_ENTER_QUAD) begin
                four_line_command_mode <= 1'b1;
            end
        end
    end

    // array fetch ahead of the link: next byte waits in tx_hold
    wire addr_done = (state == SFE_BODY) && rx_evt && (nbytes == IDX_THREE) && is_read;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_strobe <= 1'b0;
            rd_addr <= '0;
            tx_hold <= '0;
        end else begin
            rd_strobe <= addr_done || (ack_evt && state == SFE_BODY);
            if (addr_done) begin
                rd_addr <= addr_next;
            end else if (ack_evt) begin
                rd_addr <= rd_addr + ADDR_ONE;
            end
            if (rd_valid) begin
                tx_hold <= rd_data;
            end
        end
    end

    // only refreshed while select is high, so frozen during a frame
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            snap_stat <= '0;
            snap_allow <= 1'b0;
            snap_pd <= 1'b0;
        end else if (cs_q2) begin
            snap_stat <= status_in;
            snap_allow <= !busy_in && !power_down;
            snap_pd <= power_down;
        end
    end
endmodule

`default_nettype wire

// *** verification/sfe_front_end_monitor.sv ***
// assertion checker on the instruction front end ports
`timescale 1ns/1ps
`default_nettype none
module sfe_front_end_monitor import sfe_pkg::*; (
    input wire logic clk, // core clock
    input wire logic rst_n, // reset, low
    input wire logic cs_n, // select
    input wire logic [3:0] io_oe, // drive enables
    input wire logic rd_strobe, // read request
    input wire logic cmd_valid, // word waiting
    input wire logic cmd_ready, // word taken
    input wire logic [1:0] cmd_kind, // word kind
    input wire logic [7:0] cmd_data, // word byte
    input wire logic write_enable, // enable latch
    input wire logic power_down, // powered down
    input wire logic four_line_command_mode, // four-line mode
    input wire logic suspend_req, // suspend pulse
    input wire logic resume_req // resume pulse
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_oe_after_end: assert property ($rose(cs_n) |=> io_oe == 4'h0)
        else $error("drive enable left on after select rose");
    a_oe_lane_use: assert property (!four_line_command_mode |-> io_oe[3:2] == 2'h0)
        else $error("upper lines driven outside four-line mode");
    a_suspend_pulse: assert property (suspend_req |=> !suspend_req)
        else $error("suspend request longer than one cycle");
    a_resume_pulse: assert property (resume_req |-> !suspend_req ##1 !resume_req)
        else $error("resume request malformed");
    a_strobe_spacing: assert property (rd_strobe |=> !rd_strobe [*8])
        else $error("read requests too close");
    a_cmd_hold: assert property (cmd_valid && !cmd_ready |=>
        cmd_valid && $stable(cmd_kind) && $stable(cmd_data))
        else $error("command word changed while stalled");
    a_enable_moves: assert property ($changed(write_enable) |-> cs_n)
        else $error("write enable moved inside a frame");
    a_pd_moves: assert property ($changed(power_down) |-> cs_n)
        else $error("power-down moved inside a frame");
    a_quad_sticky: assert property ($rose(four_line_command_mode) |->
        cs_n ##1 four_line_command_mode [*8])
        else $error("four-line mode entry malformed");
    c_commit: cover property (cmd_valid && cmd_ready && cmd_kind == KIND_COMMIT);
    c_abort: cover property (cmd_valid && cmd_ready && cmd_kind == KIND_ABORT);
    c_read: cover property (rd_strobe);
endmodule
bind sfe_front_end sfe_front_end_monitor sfe_front_end_monitor_inst (.clk(clk), .rst_n(rst_n),
    .cs_n(cs_n), .io_oe(io_oe), .rd_strobe(rd_strobe), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_kind(cmd_kind), .cmd_data(cmd_data),
    .write_enable(write_enable), .power_down(power_down),
    .four_line_command_mode(four_line_command_mode), .suspend_req(suspend_req),
    .resume_req(resume_req));
`default_nettype wire

// *** verification/sfe_host_model.sv ***
// host serial controller model: select, link clock and data lines
`timescale 1ns/1ps
`default_nettype none
module sfe_host_model (
    output logic sclk, // link clock, still outside frames
    output logic cs_n, // select
    output logic [3:0] host_io, // host line values
    input wire logic [3:0] io_out // device line values
);
    initial begin
        sclk = 1'b0;
        cs_n <= 1'b1;
        host_io = 4'h0;
    end
    // n1 clocks on l1 lanes then n2 clocks on l2 lanes, tx msb first
    task automatic frame(input logic [63:0] tx, input int n1, l1, n2, l2,
            output logic [63:0] rx);
        int l;
        rx = 64'h0;
        #3.3 cs_n = 1'b0;
        for (int i = 0; i < n1 + n2; i++) begin
            l = (i < n1) ? l1 : l2;
            host_io = (l == 1) ? {3'h0, tx[63]} : (l == 2) ? {2'h0, tx[63:62]} : tx[63:60];
            tx = tx << l;
            #16 sclk = 1'b1;
            rx = (rx << l) | ((l == 1) ? 64'(io_out[1]) : (l == 2) ? 64'(io_out[1:0]) : 64'(io_out));
            #16 sclk = 1'b0;
        end
        #16 cs_n = 1'b1;
        // released lines show a changed level, not the last bit
        host_io = ~host_io;
    endtask
endmodule
`default_nettype wire

// *** verification/serial_flash_instruction_front_end_tb_top.sv ***
// self-checking bench for the instruction front end
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_total++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module serial_flash_instruction_front_end_tb_top import sfe_pkg::*; ;
    localparam logic [7:0] MK = 8'h5a; // arbitrary value
    localparam logic [7:0] PT = 8'h3c; // arbitrary value
    localparam logic [7:0] TY = 8'h71; // arbitrary value
    localparam logic [7:0] SZ = 8'h2e; // arbitrary value
    logic clk, rst_n, busy_in, prot_en, rd_valid, cmd_ready, stall;
    logic [15:0] status_in;
    logic [23:0] prot_base, prot_limit, a;
    logic [7:0] rd_data, b0, b1;
    logic [63:0] rx;
    logic [31:0] exp_q[$], seen_q[$], ev, sv;
    logic [9:0] cmd_q[$], c;
    int err_total, n_checks, cyc, susp_n, res_n;
    wire [3:0] io_out, io_oe, host_io, io_in;
    wire sclk, cs_n, rd_strobe, cmd_valid, write_enable, volatile_sr_enable, power_down;
    wire four_line_command_mode, suspend_req, resume_req;
    wire [23:0] rd_addr;
    wire [1:0] cmd_kind;
    wire [7:0] cmd_data;
    assign io_in = (io_oe & io_out) | (~io_oe & host_io);
    sfe_front_end #(.MAKER_CODE(MK), .PART_CODE(PT), .TYPE_CODE(TY), .SIZE_CODE(SZ))
        sfe_front_end_inst (.clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .io_in(io_in),
        .io_out(io_out), .io_oe(io_oe), .status_in(status_in), .busy_in(busy_in),
        .prot_en(prot_en), .prot_base(prot_base), .prot_limit(prot_limit),
        .rd_strobe(rd_strobe), .rd_addr(rd_addr), .rd_valid(rd_valid), .rd_data(rd_data),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_kind(cmd_kind), .cmd_data(cmd_data),
        .write_enable(write_enable), .volatile_sr_enable(volatile_sr_enable),
        .power_down(power_down), .four_line_command_mode(four_line_command_mode),
        .suspend_req(suspend_req), .resume_req(resume_req));
    sfe_host_model host_model_inst (.sclk(sclk), .cs_n(cs_n), .host_io(host_io), .io_out(io_out));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task give_verdict;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // one frame; a reply of w bits is noted for the watcher
    task link(input logic [63:0] tx, input int n1, l1, n2, l2, input logic [31:0] e, input int w);
        if (w > 0) exp_q.push_back(e);
        host_model_inst.frame(tx, n1, l1, n2, l2, rx);
        if (w > 0) seen_q.push_back(32'(rx) & ((32'h1 << w) - 32'h1));
        repeat (20) @(posedge clk);
    endtask
    // write-type frame of nb bits; whole bytes are expected as words, then fin
    task wr(input logic [7:0] op, input logic [55:0] body, input int nb, input logic [1:0] fin);
        cmd_q.push_back({KIND_OPCODE, op});
        for (int i = 1; i < nb / 8; i++) cmd_q.push_back({KIND_BYTE, body[63 - 8 * i -: 8]});
        cmd_q.push_back({fin, 8'h0});
        link({op, body}, nb, 1, 0, 1, 32'h0, 0);
    endtask
    // array side answers each read request, watcher compares notes
    always @(posedge clk) begin
        rd_valid <= rd_strobe;
        rd_data <= rd_addr[7:0] ^ 8'hc3;
        cmd_ready <= ~stall & 1'($urandom);
        cyc++;
        if (suspend_req === 1'b1) susp_n++;
        if (resume_req === 1'b1) res_n++;
        if (seen_q.size() > 0) begin
            ev = exp_q.pop_front();
            sv = seen_q.pop_front();
            `CHK("link reply", ev, sv)
        end
        if (cmd_valid === 1'b1 && cmd_ready === 1'b1) begin
            c = (cmd_q.size() > 0) ? cmd_q.pop_front() : {10{1'bx}};
            `CHK("cmd kind", c[9:8], cmd_kind)
            if (c[9:8] < KIND_COMMIT) `CHK("cmd byte", c[7:0], cmd_data)
        end
        if (cyc == 40000) begin
            err_total++;
            give_verdict;
        end
    end
    initial begin
        rst_n <= 1'b0;
        {busy_in, prot_en, stall, status_in, prot_base, prot_limit} = 67'h0;
        void'($urandom(32'hdeb0));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        status_in <= 16'($urandom);
        repeat (8) @(posedge clk);
        `CHK("oe after reset", 4'h0, io_oe)
        link({OP_STAT_LO, 56'h0}, 16, 1, 0, 1, 32'(status_in[7:0]), 8);
        link({OP_STAT_HI, 56'h0}, 16, 1, 0, 1, 32'(status_in[15:8]), 8);
        link({OP_ID_LONG, 56'h0}, 32, 1, 0, 1, 32'({MK, TY, SZ}), 24);
        link({OP_POWER_DOWN, 56'h0}, 8, 1, 0, 1, 32'h0, 0);
        `CHK("power down", 1'b1, power_down)
        link({OP_RELEASE_ID, 56'h0}, 40, 1, 0, 1, 32'(PT), 8);
        `CHK("power up", 1'b0, power_down)
        link({OP_ID_SINGLE, 56'h0}, 48, 1, 0, 1, 32'({MK, PT}), 16);
        a = 24'($urandom) & 24'h7ff000;
        link({OP_WREN, 56'h0}, 8, 1, 0, 1, 32'h0, 0);
        `CHK("enable set", 1'b1, write_enable)
        wr(OP_ERASE_4K, {a, 32'h0}, 32, KIND_COMMIT);
        `CHK("enable after commit", 1'b0, write_enable)
        link({OP_WREN, 56'h0}, 8, 1, 0, 1, 32'h0, 0);
        wr(OP_ERASE_32K, {a, 32'h0}, 30, KIND_ABORT);
        prot_en <= 1'b1;
        prot_base <= a;
        prot_limit <= a;
        wr(OP_ERASE_64K, {a, 32'h0}, 32, KIND_ABORT);
        prot_en <= 1'b0;
        `CHK("enable kept", 1'b1, write_enable)
        link({OP_WRDI, 56'h0}, 8, 1, 0, 1, 32'h0, 0);
        `CHK("enable cleared", 1'b0, write_enable)
        link({OP_VSR_WREN, 56'h0}, 8, 1, 0, 1, 32'h0, 0);
        `CHK("volatile enable", 1'b1, volatile_sr_enable)
        busy_in <= 1'b1;
        link({OP_WREN, 56'h0}, 8, 1, 0, 1, 32'h0, 0);
        `CHK("enable while busy", 1'b0, write_enable)
        link({OP_STAT_LO, 56'h0}, 16, 1, 0, 1, 32'(status_in[7:0]), 8);
        busy_in <= 1'b0;
        link({OP_WREN, 56'h0}, 8, 1, 0, 1, 32'h0, 0);
        // far side stalls until the fifo holds all eight words
        stall <= 1'b1;
        wr(OP_PAGE_PROG, {a, 24'($urandom), 8'h0}, 56, KIND_COMMIT);
        `CHK("fifo held", 1'b1, cmd_valid)
        stall <= 1'b0;
        link({OP_SUSPEND, 56'h0}, 8, 1, 0, 1, 32'h0, 0);
        link({OP_RESUME, 56'h0}, 8, 1, 0, 1, 32'h0, 0);
        `CHK("suspend pulses", 1, susp_n)
        `CHK("resume pulses", 1, res_n)
        b0 = a[7:0] ^ 8'hc3;
        b1 = (a[7:0] + 8'h1) ^ 8'hc3;
        // ends in mid-byte of the second data byte
        link({OP_READ_DUAL, a, 32'h0}, 40, 1, 6, 2, 32'({b0, b1[7:4]}), 12);
        link({OP_READ_FAST, a, 32'h0}, 48, 1, 0, 1, 32'(b0), 8);
        link({OP_ENTER_QUAD, 56'h0}, 8, 1, 0, 1, 32'h0, 0);
        `CHK("four-line mode", 1'b1, four_line_command_mode)
        link({OP_STAT_LO, 56'h0}, 2, 4, 2, 4, 32'(status_in[7:0]), 8);
        repeat (50) @(posedge clk);
        `CHK("words left", 0, cmd_q.size())
        give_verdict;
    end
endmodule
`default_nettype wire
